// ### verilog/actuator_drive_cfg.svh
// constants for the actuator drive monitor
`ifndef ACTUATOR_DRIVE_CFG_SVH
`define ACTUATOR_DRIVE_CFG_SVH
`define CLK_HZ 20000000
`define FLICKER_HZ 8
`define FLASH_HZ 2
`define SELFTEST_CYCLES 16
`define SW_RELEASE_SERVO_UPDATE 4'h3
`define ADDR_CTRL 4'h0
`define ADDR_RUNTIME 4'h1
`define ADDR_CMD 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_FAULT 4'h4
`define CTRL_RESET 16'h0000
`define RUNTIME_RESET 32'h0000_1000
`endif

// ### verilog/actuator_drive_pkg.sv
// types for the actuator drive monitor
`default_nettype none
package actuator_drive_pkg;
  typedef enum logic [2:0] {
    ST_SUPPLY = 3'h0,
    ST_SELFTEST = 3'h1,
    ST_SYNCED = 3'h2,
    ST_ADJUST = 3'h3,
    ST_CYCLIC = 3'h4,
    ST_CB_ERROR = 3'h5
  } startup_t;
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_MANUAL = 2'h1,
    SRC_AUTO = 2'h2,
    SRC_PROTECT = 2'h3
  } cmd_src_t;
  typedef struct packed {
    logic open_lim;
    logic close_lim;
    logic torque_open;
    logic torque_close;
  } field_in_t;
  typedef struct packed {
    logic torque_before_travel;
    logic torque_after_travel;
    logic run_time;
    logic discrepancy;
    logic protect_not_done;
  } faults_t;
endpackage : actuator_drive_pkg
`default_nettype wire

// ### verilog/actuator_drive_monitor.sv
// actuator drive monitor: command store, monitoring, start-up and indication
//
// Implementation choices: strobed register access and the register addresses.
`include "actuator_drive_cfg.svh"
`default_nettype none
// Behaviour
// R1: first switch-on adapts units to check-backs
// R2: no check-backs configured: assume and drive OFF
// R3: torque before travel: fault, latch, terminate
// R4: latched direction refused; opposite command clears latch
// R5: torque after travel-limit termination is a fault
// R6: run-time fault when target not reached in time
// R7: run-time fault does not stop command
// R8: late arrival clears run-time fault itself
// R9: uncommanded position change gives status discrepancy
// R10: override keeps protection commands effective
// R11: report whether protection command moved armature
// R12: report first fault only, suppress followers
// R13: other side acknowledges by command or key
// R14: record source of last reached state
// R15: blocked key inquiry lights fault lamp steadily
// R16: start on fuse, supply return, or reset command
// R17: led steady, then 8 Hz, then dark
// R18: self-test, configure, then enter cyclic operation
// R19: start-up check-back error: no commands, clear image
// R20: check-back error: 2 Hz led, steady lamp
// R21: from release 3 servo updates status bits
// R22: servo drives start in manual mode
// R23: fault sets alarm, telegram, flashing led
// R24: command held until selected termination
// R25: fault held until acknowledged or auto-cleared
module actuator_drive_monitor #(
  parameter int RT_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fuse_inserted,
  input wire logic supply_ok,
  input wire actuator_drive_pkg::field_in_t field_in,
  input wire logic key_open,
  input wire logic key_close,
  input wire logic key_enable,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic cmd_open,
  output logic cmd_close,
  output logic module_fault_led,
  output logic desk_fault_lamp,
  output logic lamp_on,
  output logic lamp_off,
  output logic lamp_stop,
  output logic servo_mode_lamp,
  output logic diagnostic_telegram
);
  localparam int FLICK_HALF = `CLK_HZ / (2 * `FLICKER_HZ);
  localparam int FLASH_HALF = `CLK_HZ / (2 * `FLASH_HZ);
  initial begin
    if (RT_W < 8 || RT_W > 32) $error("RT_W out of range");
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // ctrl: [0] checkbacks present, [1] termination_select_param (1 torque),
  // [2] protect_override_param, [3] servo, [4] configured, [5] desk tile,
  // [11:8] software release
  logic [15:0] ctrl_q;
  logic [RT_W-1:0] runtime_q;
  logic ack_pulse, reset_cmd;
  logic man_open, man_close, auto_open, auto_close, prot_open, prot_close, enable_proc;
  logic [7:0] cmd_word_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET;
      runtime_q <= RT_W'(`RUNTIME_RESET);
      cmd_word_q <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `ADDR_CTRL) ctrl_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `ADDR_RUNTIME) runtime_q <= reg_wdata[RT_W-1:0];
      if (reg_wr && reg_addr == `ADDR_CMD) cmd_word_q <= reg_wdata[7:0];
      else cmd_word_q <= {cmd_word_q[7], 7'h00}; // commands are brief
    end
  end
  assign ack_pulse = reg_wr && reg_addr == `ADDR_CMD && reg_wdata[8]; // R13
  assign reset_cmd = reg_wr && reg_addr == `ADDR_CMD && reg_wdata[9];
  assign man_open = cmd_word_q[0];
  assign man_close = cmd_word_q[1];
  assign auto_open = cmd_word_q[2];
  assign auto_close = cmd_word_q[3];
  assign prot_open = cmd_word_q[4];
  assign prot_close = cmd_word_q[5];
  assign enable_proc = cmd_word_q[7];
  // ------------------------------------------------------------
  // start-up sequencing
  // ------------------------------------------------------------
  actuator_drive_pkg::startup_t st_q;
  logic [7:0] test_cnt_q;
  logic supply_q, fuse_q, restart;
  logic cb_error;
  assign cb_error = ctrl_q[0] && field_in.open_lim && field_in.close_lim;
  always_ff @(posedge clk) begin
    if (rst) begin
      supply_q <= 1'b0;
      fuse_q <= 1'b0;
    end else begin
      supply_q <= supply_ok;
      fuse_q <= fuse_inserted;
    end
  end
  assign restart = (supply_ok && !supply_q) || (fuse_inserted && !fuse_q) || reset_cmd; // R16
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      st_q <= actuator_drive_pkg::ST_SUPPLY;
      test_cnt_q <= 8'h00;
    end else begin
      unique case (st_q)
        actuator_drive_pkg::ST_SUPPLY: if (supply_ok) st_q <= actuator_drive_pkg::ST_SELFTEST;
        actuator_drive_pkg::ST_SELFTEST: begin
          // processor, memory and bus checks are stood in for by a fixed interval
          test_cnt_q <= test_cnt_q + 8'h01;
          if (test_cnt_q == 8'(`SELFTEST_CYCLES)) st_q <= actuator_drive_pkg::ST_SYNCED; // R18
        end
        actuator_drive_pkg::ST_SYNCED: if (ctrl_q[4]) st_q <= actuator_drive_pkg::ST_ADJUST; // R18
        actuator_drive_pkg::ST_ADJUST: begin
          if (cb_error) st_q <= actuator_drive_pkg::ST_CB_ERROR; // R19
          else st_q <= actuator_drive_pkg::ST_CYCLIC;
        end
        actuator_drive_pkg::ST_CYCLIC: st_q <= actuator_drive_pkg::ST_CYCLIC;
        actuator_drive_pkg::ST_CB_ERROR: st_q <= actuator_drive_pkg::ST_CB_ERROR;
        default: st_q <= actuator_drive_pkg::ST_SUPPLY;
      endcase
    end
  end
  logic cyclic;
  assign cyclic = st_q == actuator_drive_pkg::ST_CYCLIC;
  // ------------------------------------------------------------
  // position adjustment and command store
  // ------------------------------------------------------------
  logic pos_open_q, pos_close_q; // believed position
  logic run_open_q, run_close_q;
  logic lat_open_q, lat_close_q;
  logic req_open, req_close, blk_open, blk_close;
  logic [1:0] src_run_q;
  assign blk_open = lat_open_q || (!enable_proc && !lat_close_q) || auto_close || prot_close;
  assign blk_close = lat_close_q || (!enable_proc && !lat_open_q) || auto_open || prot_open;
  // opposite-direction travel runs without process enable while a latch is set
  assign req_open = prot_open || auto_open || (man_open && (enable_proc || lat_close_q)); // R4
  assign req_close = prot_close || auto_close || (man_close && (enable_proc || lat_open_q)); // R4
  logic prot_ok;
  actuator_drive_pkg::faults_t flt_q;
  assign prot_ok = ctrl_q[2] || !(flt_q.discrepancy || cb_error); // R10
  logic open_reached, close_reached;
  assign open_reached = ctrl_q[1] ? field_in.torque_open : field_in.open_lim; // R24
  assign close_reached = ctrl_q[1] ? field_in.torque_close : field_in.close_lim; // R24
  always_ff @(posedge clk) begin
    if (rst || !cyclic) begin
      run_open_q <= 1'b0;
      run_close_q <= 1'b0;
      src_run_q <= actuator_drive_pkg::SRC_NONE;
      if (st_q == actuator_drive_pkg::ST_ADJUST) begin
        pos_open_q <= ctrl_q[0] && field_in.open_lim; // R1
        pos_close_q <= !ctrl_q[0] || field_in.close_lim; // R2
      end else if (rst) begin
        pos_open_q <= 1'b0;
        pos_close_q <= 1'b0;
      end
    end else begin
      if (req_open && !lat_open_q && (prot_ok || !prot_open)) begin
        run_open_q <= 1'b1;
        run_close_q <= 1'b0;
        src_run_q <= prot_open ? actuator_drive_pkg::SRC_PROTECT :
                     auto_open ? actuator_drive_pkg::SRC_AUTO : actuator_drive_pkg::SRC_MANUAL;
      end else if (req_close && !lat_close_q && (prot_ok || !prot_close)) begin
        run_close_q <= 1'b1;
        run_open_q <= 1'b0;
        src_run_q <= prot_close ? actuator_drive_pkg::SRC_PROTECT :
                     auto_close ? actuator_drive_pkg::SRC_AUTO : actuator_drive_pkg::SRC_MANUAL;
      end else begin
        // stored until termination; torque always terminates
        if (open_reached || field_in.torque_open) run_open_q <= 1'b0; // R24 R3
        if (close_reached || field_in.torque_close) run_close_q <= 1'b0; // R24 R3
      end
      if (!ctrl_q[0]) begin
        pos_close_q <= 1'b1;
        pos_open_q <= 1'b0;
      end else begin
        if (field_in.open_lim) pos_open_q <= 1'b1;
        if (field_in.close_lim) pos_close_q <= 1'b1;
        if (run_open_q || run_close_q) begin
          if (!field_in.open_lim) pos_open_q <= 1'b0;
          if (!field_in.close_lim) pos_close_q <= 1'b0;
        end
      end
    end
  end
  // torque latch per direction
  always_ff @(posedge clk) begin
    if (rst) begin
      lat_open_q <= 1'b0;
      lat_close_q <= 1'b0;
    end else begin
      if (field_in.torque_open && !field_in.open_lim) lat_open_q <= 1'b1; // R3
      else if (req_close) lat_open_q <= 1'b0; // R4
      if (field_in.torque_close && !field_in.close_lim) lat_close_q <= 1'b1; // R3
      else if (req_open) lat_close_q <= 1'b0; // R4
    end
  end
  // ------------------------------------------------------------
  // monitoring
  // ------------------------------------------------------------
  logic [RT_W-1:0] rt_cnt_q;
  logic moved_q, any_q;
  logic [2:0] last_src_q;
  always_ff @(posedge clk) begin
    if (rst || !(run_open_q || run_close_q)) rt_cnt_q <= '0;
    else if (rt_cnt_q != runtime_q) rt_cnt_q <= rt_cnt_q + 1'b1; // R6
  end
  actuator_drive_pkg::faults_t raw;
  always_comb begin
    raw = '0;
    raw.torque_before_travel = (field_in.torque_open && !field_in.open_lim) ||
                               (field_in.torque_close && !field_in.close_lim); // R3
    raw.torque_after_travel = !ctrl_q[1] && ((field_in.torque_open && field_in.open_lim) ||
                              (field_in.torque_close && field_in.close_lim)); // R5
    raw.run_time = (run_open_q || run_close_q) && rt_cnt_q == runtime_q; // R6 R7
    raw.discrepancy = ctrl_q[0] && !run_open_q && !run_close_q &&
                      ((pos_open_q && !field_in.open_lim) ||
                       (pos_close_q && !field_in.close_lim)); // R9
    raw.protect_not_done = src_run_q == actuator_drive_pkg::SRC_PROTECT &&
                           raw.run_time && !moved_q; // R11
  end
  always_ff @(posedge clk) begin
    if (rst || !cyclic) begin
      flt_q <= '0;
      moved_q <= 1'b0;
    end else begin
      moved_q <= (run_open_q || run_close_q) &&
                 (moved_q || !(field_in.open_lim || field_in.close_lim));
      // first cause only: followers suppressed while any fault stands; set beats ack
      if (flt_q == '0) flt_q <= raw; // R12 R25
      else if (ack_pulse || (key_open || key_close) && !key_enable) flt_q <= raw; // R13
      else if (flt_q.run_time && (open_reached || close_reached)) flt_q.run_time <= 1'b0; // R8
    end
  end
  assign any_q = flt_q != '0;
  always_ff @(posedge clk) begin
    if (rst) last_src_q <= 3'h0;
    else if ((run_open_q && open_reached) || (run_close_q && close_reached))
      last_src_q <= {1'b1, src_run_q}; // R14
  end
  // ------------------------------------------------------------
  // indication
  // ------------------------------------------------------------
  logic [23:0] blink_q;
  logic flick_q, flash_q, inquiry_q, telegram_q;
  always_ff @(posedge clk) begin
    if (rst || blink_q == 24'(FLASH_HALF - 1)) blink_q <= '0;
    else blink_q <= blink_q + 24'h000001;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      flick_q <= 1'b0;
      flash_q <= 1'b0;
      inquiry_q <= 1'b0;
      telegram_q <= 1'b0;
    end else begin
      if (blink_q % 24'(FLICK_HALF) == 24'h0) flick_q <= !flick_q; // R17
      if (blink_q == 24'h0) flash_q <= !flash_q; // R20
      inquiry_q <= !key_enable && ((key_open && blk_open) || (key_close && blk_close)); // R15
      telegram_q <= raw != '0 && flt_q == '0; // R23
    end
  end
  always_comb begin
    unique case (st_q)
      actuator_drive_pkg::ST_SUPPLY, actuator_drive_pkg::ST_SELFTEST: module_fault_led = 1'b1;
      actuator_drive_pkg::ST_SYNCED, actuator_drive_pkg::ST_ADJUST: module_fault_led = flick_q;
      actuator_drive_pkg::ST_CB_ERROR: module_fault_led = flash_q; // R20
      default: module_fault_led = any_q && flash_q; // R23
    endcase
  end
  logic cberr;
  assign cberr = st_q == actuator_drive_pkg::ST_CB_ERROR;
  assign desk_fault_lamp = ctrl_q[5] && (cberr || inquiry_q); // R20 R15
  assign cmd_open = cyclic && run_open_q; // R19
  assign cmd_close = cyclic && (run_close_q || !ctrl_q[0]); // R2 R19
  assign lamp_on = ctrl_q[5] && !cberr && pos_open_q;
  assign lamp_off = ctrl_q[5] && !cberr && pos_close_q;
  assign lamp_stop = ctrl_q[5] && !cberr && cyclic && !run_open_q && !run_close_q;
  // servo starts in manual open-loop mode; lamp shows that mode
  assign servo_mode_lamp = ctrl_q[5] && ctrl_q[3] && cyclic; // R22 R20
  assign diagnostic_telegram = telegram_q;
  // ------------------------------------------------------------
  // input process image readback
  // ------------------------------------------------------------
  logic [31:0] image;
  logic servo_upd;
  assign servo_upd = !ctrl_q[3] || ctrl_q[11:8] >= `SW_RELEASE_SERVO_UPDATE; // R21
  always_comb begin
    image = 32'h0000_0000;
    // kept bits a..d live in the top four bits [31:28] and survive a check-back error
    image[31:28] = {lat_open_q, lat_close_q, pos_open_q, pos_close_q}; // R19
    if (!cberr) begin
      image[0] = any_q; // R23
      image[5:1] = flt_q; // R12
      image[8:6] = last_src_q; // R14
      image[9] = run_open_q;
      image[10] = run_close_q;
      if (servo_upd) begin
        image[11] = pos_open_q || pos_close_q;
        image[12] = blk_open || blk_close;
        image[13] = !run_open_q && !run_close_q;
        image[14] = !any_q;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) reg_rdata <= 32'h0000_0000;
    else if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_CTRL: reg_rdata <= {16'h0000, ctrl_q};
        `ADDR_RUNTIME: reg_rdata <= 32'(runtime_q);
        `ADDR_STATUS: reg_rdata <= image;
        `ADDR_FAULT: reg_rdata <= {24'h000000, 5'(st_q), 3'h0};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else reg_rdata <= 32'h0000_0000;
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_no_cmd_cberr: assert property (@(posedge clk) disable iff (rst)
    cberr |-> !cmd_open && !cmd_close) else $error("command during check-back error"); // R19
  a_lamp_cberr: assert property (@(posedge clk) disable iff (rst)
    cberr && ctrl_q[5] |-> desk_fault_lamp && !lamp_on && !lamp_stop)
    else $error("desk lamps wrong in check-back error"); // R20
  a_latch_blocks: assert property (@(posedge clk) disable iff (rst)
    cyclic && lat_open_q && !req_close |=> !run_open_q || $past(run_open_q))
    else $error("latched direction started"); // R4
  a_runtime_keep: assert property (@(posedge clk) disable iff (rst || !cyclic)
    raw.run_time && !open_reached && !close_reached && !field_in.torque_open
    && !field_in.torque_close && !req_open && !req_close |=> run_open_q || run_close_q)
    else $error("run-time fault stopped command"); // R7
  a_led_steady: assert property (@(posedge clk) disable iff (rst)
    st_q == actuator_drive_pkg::ST_SELFTEST |-> module_fault_led)
    else $error("led not steady before sync"); // R17
  a_torque_term: assert property (@(posedge clk) disable iff (rst || !cyclic)
    run_open_q && field_in.torque_open && !req_open |=> !run_open_q)
    else $error("torque did not terminate"); // R3
  a_tbt_flag: assert property (@(posedge clk) disable iff (rst || !cyclic)
    flt_q == '0 && raw.torque_before_travel |=> flt_q.torque_before_travel)
    else $error("torque fault not flagged"); // R3
  a_telegram: assert property (@(posedge clk) disable iff (rst)
    cyclic && raw != '0 && flt_q == '0 |=> diagnostic_telegram)
    else $error("no telegram on fault"); // R23
endmodule : actuator_drive_monitor
`default_nettype wire

// ### tb/actuator_field_model.sv
// field actuator model: armature travel, limit contacts and torque contacts
`default_nettype none
module actuator_field_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_open,
  input wire logic cmd_close,
  input wire logic stuck,
  input wire logic both_lim,
  input wire logic jump,
  input wire logic [15:0] travel,
  input wire logic [15:0] jump_pos,
  output var actuator_drive_pkg::field_in_t field_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] pos_q;
  logic [2:0] over_q;
  logic at_end;
  // ----------------------------------------
  // armature travel, one step per cycle
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_q <= 16'h0000;
    end else if (jump) begin
      pos_q <= jump_pos;
    end else if (!stuck && cmd_open && pos_q < travel) begin
      pos_q <= pos_q + 16'h0001;
    end else if (!stuck && cmd_close && pos_q != 16'h0000) begin
      pos_q <= pos_q - 16'h0001;
    end
  end
  // ----------------------------------------
  // contacts
  // ----------------------------------------
  // driving on into the seat builds torque after a few cycles; a stall builds it at once
  assign at_end = (cmd_open && pos_q == travel) || (cmd_close && pos_q == 16'h0000);
  always_ff @(posedge clk) begin
    if (rst || !at_end) begin
      over_q <= 3'h0;
    end else if (over_q != 3'h7) begin
      over_q <= over_q + 3'h1;
    end
  end
  assign field_in = {both_lim || pos_q == travel, both_lim || pos_q == 16'h0000,
                     cmd_open && (stuck || over_q >= 3'h3),
                     cmd_close && (stuck || over_q >= 3'h3)};
endmodule : actuator_field_model
`default_nettype wire

// ### tb/test_actuator_drive_monitor.sv
// testbench for the actuator drive monitor
`default_nettype none
module test_actuator_drive_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RT = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic supply_ok = 1'b1;
  logic fuse_inserted = 1'b0;
  logic key_open = 1'b0;
  logic key_close = 1'b0;
  logic key_enable = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic stuck = 1'b0;
  logic both_lim = 1'b0;
  logic jump = 1'b0;
  logic [15:0] travel = 16'h0;
  logic [15:0] jump_pos = 16'h0;
  logic [31:0] reg_rdata;
  logic [31:0] img;
  logic cmd_open, cmd_close, led, desk_lamp, lamp_on, lamp_off, lamp_stop, servo_lamp, tel;
  actuator_drive_pkg::field_in_t field_in;
  int bad_count = 0;
  int check_count = 0;
  int tel_count = 0;
  logic [3:0] a;
  actuator_drive_monitor dut (.clk(clk), .rst(rst), .fuse_inserted(fuse_inserted),
    .supply_ok(supply_ok), .field_in(field_in), .key_open(key_open), .key_close(key_close),
    .key_enable(key_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_open(cmd_open), .cmd_close(cmd_close),
    .module_fault_led(led), .desk_fault_lamp(desk_lamp), .lamp_on(lamp_on),
    .lamp_off(lamp_off), .lamp_stop(lamp_stop), .servo_mode_lamp(servo_lamp),
    .diagnostic_telegram(tel));
  actuator_field_model field (.clk(clk), .rst(rst), .cmd_open(cmd_open),
    .cmd_close(cmd_close), .stuck(stuck), .both_lim(both_lim), .jump(jump),
    .travel(travel), .jump_pos(jump_pos), .field_in(field_in));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (tel === 1'b1) tel_count++;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task chk(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task wr(logic [3:0] ad, logic [31:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(logic [3:0] ad);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 img = reg_rdata;
  endtask : rd
  function automatic logic [2:0] src_bits(logic [1:0] s);
    return {1'b1, s};
  endfunction : src_bits
  // one full travel, slower than the monitoring time
  task move(logic [31:0] word, bit dir, logic [1:0] src);
    int n;
    int t0;
    t0 = tel_count;
    n = 0;
    wr(4'h2, word);
    cyc(RT + 4);
    chk("held", 1'b1, dir ? cmd_open : cmd_close);
    rd(4'h3);
    chk("faults", 6'b001001, img[5:0]);
    chk("telegram", t0 + 1, tel_count);
    while ((dir ? cmd_open : cmd_close) === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("at limit", 1'b1, dir ? field_in.open_lim : field_in.close_lim);
    rd(4'h3);
    chk("runtime gone", 1'b0, img[3]);
    chk("source", src_bits(src), img[8:6]);
    chk("position", dir ? 2'b10 : 2'b01, img[29:28]);
    wr(4'h2, 32'h0000_0180);
  endtask : move
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(64));
    travel = 16'(RT + 12 + $urandom % 16);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc(5);
    chk("led start", 1'b1, led);
    wr(4'h1, RT);
    cyc(20);
    chk("no cmd unconfigured", 2'b00, {cmd_open, cmd_close});
    wr(4'h0, 32'h0000_0331);
    cyc(4);
    chk("led cyclic", 1'b0, led);
    rd(4'h3);
    chk("adapted", 32'h1000_0000, img & 32'hF000_003F);
    move(32'h0000_0084, 1'b1, 2'h2);
    move(32'h0000_0082, 1'b0, 2'h1);
    move(32'h0000_0090, 1'b1, 2'h3);
    @(posedge clk) stuck <= 1'b1;
    wr(4'h2, 32'h0000_0082);
    cyc(6);
    chk("tbt stop", 1'b0, cmd_close);
    rd(4'h3);
    chk("tbt", 32'h4000_0021, img & 32'h4000_003F);
    @(posedge clk) stuck <= 1'b0;
    wr(4'h2, 32'h0000_0180);
    wr(4'h2, 32'h0000_0082);
    cyc(6);
    chk("refused", 1'b0, cmd_close);
    wr(4'h2, 32'h0000_0001);
    cyc(4);
    rd(4'h3);
    chk("latch gone", 1'b0, img[30]);
    // let the opposite run reach its limit so no command is active at the drift
    cyc(RT + 60);
    chk("reverse done", 1'b0, cmd_open);
    wr(4'h2, 32'h0000_0180);
    // drift off the open limit with no command given
    @(posedge clk) jump_pos <= travel / 2;
    jump <= 1'b1;
    @(posedge clk) jump <= 1'b0;
    cyc(4);
    rd(4'h3);
    chk("discrepancy", 5'b00010, img[5:1]);
    chk("no move", 2'b00, {cmd_open, cmd_close});
    @(posedge clk) jump_pos <= travel;
    jump <= 1'b1;
    @(posedge clk) jump <= 1'b0;
    cyc(4);
    rd(4'h3);
    chk("fault held", 5'b00010, img[5:1]);
    wr(4'h2, 32'h0000_0000);
    @(posedge clk) key_close <= 1'b1;
    cyc(4);
    chk("block lamp", 1'b1, desk_lamp);
    @(posedge clk) key_close <= 1'b0;
    cyc(3);
    rd(4'h3);
    chk("key ack", 6'b000000, img[5:0]);
    // restart with both limits made: check-back error
    @(posedge clk) both_lim <= 1'b1;
    fuse_inserted <= 1'b1;
    cyc(3);
    chk("led restart", 1'b1, led);
    cyc(20);
    wr(4'h0, 32'h0000_0331);
    cyc(4);
    chk("cb outputs", 6'h00, {cmd_open, cmd_close, lamp_on, lamp_off, lamp_stop,
        servo_lamp});
    chk("cb lamp", 1'b1, desk_lamp);
    rd(4'h3);
    chk("cb image", 28'h0, img[27:0]);
    for (int i = 0; i < 4; i++) begin
      a = 4'(5 + $urandom % 11);
      wr(a, $urandom);
      rd(a);
      chk("unmapped", 32'h0, img);
    end
    end_sim;
  end
  initial begin
    #(20000 * 50);
    bad_count++;
    end_sim;
  end
endmodule : test_actuator_drive_monitor
`default_nettype wire
